// File: rtl/ntbx_translate.sv
// Operation
// - One shared 64-entry id mapping table serves all id translation.
// - Entry bit 0 is valid; only valid entries join lookups.
// - Entry bits 3:1 hold initiator function number.
// - Entry bits 8:4 hold initiator slot number.
// - Entry bits 16:9 hold initiator bus number.
// - Entry bits 19:17 hold initiator partition.
// - Entry bit 29 selects address type handling on requests.
// - Bit 30 completion snoop handling, bit 31 request snoop handling.
// - Requests compare requester id and partition with every valid entry.
// - Matched request gets destination endpoint bus number.
// - Matched request slot bit 4 set, bit 3 cleared.
// - Low slot bits and function bits carry the match index.
// - Completion lookup only when requester id bits 7:6 are 10.
// - Low six bits of requester id low byte index the table.
// - Valid indexed completion goes to the entry partition.
// - Completion requester id restored from entry fields.
// - Completion completer id becomes emitting endpoint id.
// - Memory request address compared against bars 0 to 5.
// - Lut bar hit selects entry, partition, base, adds offset.
// - Bar0 hit is a local register access, not forwarded.
// - A lut bar has 12 entries, equal slices of the window.
// - Capture register returns the id of its last reader.
`default_nettype none
module ntbx_translate (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Packet header in
    input wire logic hdr_valid,
    input wire logic hdr_is_cpl,
    input wire logic [2:0] hdr_src_part,
    input wire logic [15:0] hdr_req_id,
    input wire logic [15:0] hdr_cpl_id,
    input wire logic [63:0] hdr_addr,
    // Translated header out
    output logic out_valid,
    output logic [1:0] out_kind,
    output logic [2:0] out_part,
    output logic [15:0] out_req_id,
    output logic [15:0] out_cpl_id,
    output logic [63:0] out_addr,
    output logic [2:0] out_bar,
    output logic out_addr_type,
    output logic out_cpl_snoop,
    output logic out_req_snoop
);
    typedef struct packed {
        logic [ntbx_pkg::MAP_ENTRIES-1:0][31:0] map;
        logic [ntbx_pkg::NUM_BARS-1:0][63:0] bar_base;
        logic [ntbx_pkg::NUM_BARS-1:0][63:0] bar_mask;
        logic [ntbx_pkg::NUM_BARS-1:0][15:0] bar_cfg;
        logic [ntbx_pkg::NUM_BARS-1:0][63:0] dir_base;
        logic [ntbx_pkg::LUT_ENTRIES-1:0][63:0] lut;
        logic [ntbx_pkg::NUM_PARTS-1:0][15:0] ep_id;
        logic [15:0] capture;
        logic [31:0] drops;
        logic awready;
        logic wready;
        logic have_aw;
        logic have_w;
        logic [11:0] aw;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ovalid;
        logic [1:0] okind;
        logic [2:0] opart;
        logic [15:0] oreq;
        logic [15:0] ocpl;
        logic [63:0] oaddr;
        logic [2:0] obar;
        logic oat;
        logic ocs;
        logic ors;
    } ntbx_state_t;

    ntbx_state_t st_reg;
    ntbx_state_t st_next;

    // Register word select: map (64 words), bars use two words for 64-bit values
    function automatic logic [31:0] rd_word(input ntbx_state_t s, input logic [11:0] a);
        logic [31:0] v;
        logic [2:0] b;
        v = 32'h0000_0000;
        b = a[5:3];
        if (a < ntbx_pkg::A_BAR_BASE)
            v = s.map[a[7:2]];
        else if (a < ntbx_pkg::A_BAR_MASK)
            v = (b < 3'h6) ? (a[2] ? s.bar_base[b][63:32] : s.bar_base[b][31:0]) : 32'h0;
        else if (a < ntbx_pkg::A_BAR_CFG)
            v = (b < 3'h6) ? (a[2] ? s.bar_mask[b][63:32] : s.bar_mask[b][31:0]) : 32'h0;
        else if (a < ntbx_pkg::A_DIR_BASE)
            v = (a[4:2] < 3'h6) ? {16'h0000, s.bar_cfg[a[4:2]]} : 32'h0;
        else if (a < ntbx_pkg::A_LUT_BASE)
            v = (b < 3'h6) ? (a[2] ? s.dir_base[b][63:32] : s.dir_base[b][31:0]) : 32'h0;
        else if (a < ntbx_pkg::A_EP_ID)
            v = (a[6:3] < 4'(ntbx_pkg::LUT_ENTRIES))
                ? s.lut[a[6:3]][{a[2], 5'h00} +: 32] : 32'h0;
        else if (a < ntbx_pkg::A_LOC_CFG)
            v = {16'h0000, s.ep_id[a[4:2]]};
        else if (a == ntbx_pkg::A_CAPTURE)
            v = {16'h0000, s.capture};
        else if (a == ntbx_pkg::A_STATUS)
            v = s.drops;
        return v;
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = n[i*8 +: 8];
        return r;
    endfunction
    // Combinational lookup results
    logic req_hit;
    logic [5:0] req_idx;
    logic bar_hit;
    logic [2:0] bar_num;
    logic [63:0] offs;
    logic [3:0] lut_idx;
    logic [5:0] cidx;
    logic [31:0] cent;
    logic [63:0] lut_e;

    always_comb
    begin
        // Request id search: lowest valid matching index wins
        req_hit = 1'b0;
        req_idx = 6'h00;
        for (int i = ntbx_pkg::MAP_ENTRIES - 1; i >= 0; i--)
        begin
            if (st_reg.map[i][ntbx_pkg::F_VALID]
                && st_reg.map[i][ntbx_pkg::F_FN_LO +: 16] == hdr_req_id
                && st_reg.map[i][ntbx_pkg::F_PART_LO +: 3] == hdr_src_part)
            begin
                req_hit = 1'b1;
                req_idx = i[5:0];
            end
        end
        // Bar compare; bar0 has priority as the register window
        bar_hit = 1'b0;
        bar_num = 3'h0;
        for (int b = ntbx_pkg::NUM_BARS - 1; b >= 0; b--)
        begin
            if (st_reg.bar_cfg[b][ntbx_pkg::BC_EN]
                && (hdr_addr & st_reg.bar_mask[b]) == st_reg.bar_base[b])
            begin
                bar_hit = 1'b1;
                bar_num = b[2:0];
            end
        end
        offs = hdr_addr & ~st_reg.bar_mask[bar_num];
        // Equal slices: slice size is a power of two set per bar
        lut_idx = 4'(offs >> st_reg.bar_cfg[bar_num][ntbx_pkg::BC_SHIFT_LO +: 6]);
        lut_e = (lut_idx < 4'(ntbx_pkg::LUT_ENTRIES)) ? st_reg.lut[lut_idx] : 64'h0;
        cidx = hdr_req_id[5:0];
        cent = st_reg.map[cidx];
    end

    // Single state update process
    always_comb
    begin
        logic [11:0] wa;
        logic [31:0] wv;
        logic [2:0] wb;
        logic [2:0] dp;
        wa = 12'h000;
        wv = 32'h0;
        wb = 3'h0;
        dp = 3'h0;
        st_next = st_reg;
        // Address and data taken in either order
        if (s_awvalid && st_reg.awready)
        begin
            st_next.have_aw = 1'b1;
            st_next.aw = s_awaddr;
            st_next.awready = 1'b0;
        end
        if (s_wvalid && st_reg.wready)
        begin
            st_next.have_w = 1'b1;
            st_next.wd = s_wdata;
            st_next.ws = s_wstrb;
            st_next.wready = 1'b0;
        end
        if (st_reg.have_aw && st_reg.have_w && !st_reg.bvalid)
        begin
            wa = {st_reg.aw[11:2], 2'b00};
            wb = wa[5:3];
            st_next.bvalid = 1'b1;
            st_next.bresp = ntbx_pkg::RESP_OKAY;
            st_next.have_aw = 1'b0;
            st_next.have_w = 1'b0;
            if (wa < ntbx_pkg::A_BAR_BASE)
            begin
                // Software fills permitted initiators here
                wv = merge(st_reg.map[wa[7:2]], st_reg.wd, st_reg.ws);
                st_next.map[wa[7:2]] = wv & ntbx_pkg::MAP_WMASK;
            end
            else if (wa < ntbx_pkg::A_BAR_MASK && wb < 3'h6)
                st_next.bar_base[wb][{wa[2], 5'h00} +: 32] =
                    merge(st_reg.bar_base[wb][{wa[2], 5'h00} +: 32], st_reg.wd, st_reg.ws);
            else if (wa < ntbx_pkg::A_BAR_CFG && wb < 3'h6)
                st_next.bar_mask[wb][{wa[2], 5'h00} +: 32] =
                    merge(st_reg.bar_mask[wb][{wa[2], 5'h00} +: 32], st_reg.wd, st_reg.ws);
            else if (wa >= ntbx_pkg::A_BAR_CFG && wa < ntbx_pkg::A_DIR_BASE && wa[4:2] < 3'h6)
            begin
                wv = merge({16'h0000, st_reg.bar_cfg[wa[4:2]]}, st_reg.wd, st_reg.ws);
                st_next.bar_cfg[wa[4:2]] = wv[15:0];
            end
            else if (wa >= ntbx_pkg::A_DIR_BASE && wa < ntbx_pkg::A_LUT_BASE && wb < 3'h6)
                st_next.dir_base[wb][{wa[2], 5'h00} +: 32] =
                    merge(st_reg.dir_base[wb][{wa[2], 5'h00} +: 32], st_reg.wd, st_reg.ws);
            else if (wa >= ntbx_pkg::A_LUT_BASE && wa < ntbx_pkg::A_EP_ID
                     && wa[6:3] < 4'(ntbx_pkg::LUT_ENTRIES))
                st_next.lut[wa[6:3]][{wa[2], 5'h00} +: 32] =
                    merge(st_reg.lut[wa[6:3]][{wa[2], 5'h00} +: 32], st_reg.wd, st_reg.ws);
            else if (wa >= ntbx_pkg::A_EP_ID && wa < ntbx_pkg::A_LOC_CFG)
            begin
                wv = merge({16'h0000, st_reg.ep_id[wa[4:2]]}, st_reg.wd, st_reg.ws);
                st_next.ep_id[wa[4:2]] = wv[15:0];
            end
            else if (wa == ntbx_pkg::A_STATUS)
                st_next.drops = 32'h0;
            else
                st_next.bresp = ntbx_pkg::RESP_SLVERR;
        end
        if (st_reg.bvalid && s_bready)
        begin
            st_next.bvalid = 1'b0;
            st_next.awready = 1'b1;
            st_next.wready = 1'b1;
        end
        // Read: one cycle after the address is taken
        if (s_arvalid && st_reg.arready)
        begin
            st_next.arready = 1'b0;
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_word(st_reg, {s_araddr[11:2], 2'b00});
            st_next.rresp = ntbx_pkg::RESP_OKAY;
        end
        if (st_reg.rvalid && s_rready)
        begin
            st_next.rvalid = 1'b0;
            st_next.arready = 1'b1;
        end
        // Header translation, one cycle latency
        st_next.ovalid = hdr_valid;
        st_next.okind = ntbx_pkg::K_DROP;
        st_next.opart = 3'h0;
        st_next.oreq = hdr_req_id;
        st_next.ocpl = hdr_cpl_id;
        st_next.oaddr = hdr_addr;
        st_next.obar = bar_num;
        st_next.oat = 1'b0;
        st_next.ocs = 1'b0;
        st_next.ors = 1'b0;
        if (hdr_valid && hdr_is_cpl)
        begin
            if (hdr_req_id[7:6] == ntbx_pkg::CPL_TAG
                && cent[ntbx_pkg::F_VALID])
            begin
                dp = cent[ntbx_pkg::F_PART_LO +: 3];
                st_next.okind = ntbx_pkg::K_FWD;
                st_next.opart = dp;
                st_next.oreq = cent[ntbx_pkg::F_FN_LO +: 16];
                st_next.ocpl = st_reg.ep_id[dp];
                st_next.ocs = cent[ntbx_pkg::F_CSH];
            end
        end
        else if (hdr_valid && bar_hit && bar_num == 3'h0)
            st_next.okind = ntbx_pkg::K_LOCAL;
        else if (hdr_valid && bar_hit && req_hit)
        begin
            if (st_reg.bar_cfg[bar_num][ntbx_pkg::BC_LUT])
            begin
                dp = lut_e[ntbx_pkg::L_PART_LO +: 3];
                st_next.okind = lut_e[ntbx_pkg::L_VALID] ? ntbx_pkg::K_FWD
                                                         : ntbx_pkg::K_DROP;
                st_next.oaddr = {lut_e[63:4], 4'h0} + offs;
            end
            else
            begin
                dp = st_reg.bar_cfg[bar_num][ntbx_pkg::BC_PART_LO +: 3];
                st_next.okind = ntbx_pkg::K_FWD;
                st_next.oaddr = st_reg.dir_base[bar_num] + offs;
            end
            st_next.opart = dp;
            // Bus of the destination endpoint, slot 1_0xxx, index in low six bits
            st_next.oreq = {st_reg.ep_id[dp][15:8], 2'b10, req_idx};
            st_next.oat = st_reg.map[req_idx][ntbx_pkg::F_ATH];
            st_next.ors = st_reg.map[req_idx][ntbx_pkg::F_RSH];
        end
        if (hdr_valid && st_next.okind == ntbx_pkg::K_DROP)
            st_next.drops = st_reg.drops + 32'h1;
        // Capture the id of whoever reads the capture word
        if (hdr_valid && st_next.okind == ntbx_pkg::K_LOCAL
            && offs[11:0] == ntbx_pkg::A_CAPTURE)
            st_next.capture = hdr_req_id;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= '0;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // Outputs straight from state
    assign s_awready = st_reg.awready;
    assign s_wready = st_reg.wready;
    assign s_bresp = st_reg.bresp;
    assign s_bvalid = st_reg.bvalid;
    assign s_arready = st_reg.arready;
    assign s_rdata = st_reg.rdata;
    assign s_rresp = st_reg.rresp;
    assign s_rvalid = st_reg.rvalid;
    assign out_valid = st_reg.ovalid;
    assign out_kind = st_reg.okind;
    assign out_part = st_reg.opart;
    assign out_req_id = st_reg.oreq;
    assign out_cpl_id = st_reg.ocpl;
    assign out_addr = st_reg.oaddr;
    assign out_bar = st_reg.obar;
    assign out_addr_type = st_reg.oat;
    assign out_cpl_snoop = st_reg.ocs;
    assign out_req_snoop = st_reg.ors;

    // Assertions
    a_cpl_gate_tag: assert property (@(posedge aclk) disable iff (!aresetn)
        hdr_valid && hdr_is_cpl && hdr_req_id[7:6] != 2'h2 |=> out_kind == 2'h0)
        else $error("completion with bad tag forwarded");
    a_cpl_part_ok: assert property (@(posedge aclk) disable iff (!aresetn)
        hdr_valid && hdr_is_cpl && hdr_req_id[7:6] == 2'h2 && cent[0]
        |=> out_part == $past(cent[19:17]) && out_req_id == $past(cent[16:1]))
        else $error("completion not restored");
    a_cpl_inval: assert property (@(posedge aclk) disable iff (!aresetn)
        hdr_valid && hdr_is_cpl && !cent[0] |=> out_kind == 2'h0)
        else $error("invalid completion forwarded");
    a_cpl_cplid: assert property (@(posedge aclk) disable iff (!aresetn)
        out_valid && out_kind == 2'h1 && $past(hdr_is_cpl)
        |-> out_cpl_id == st_reg.ep_id[out_part])
        else $error("completer id wrong");
    a_req_slot: assert property (@(posedge aclk) disable iff (!aresetn)
        out_valid && out_kind == 2'h1 && !$past(hdr_is_cpl) |-> out_req_id[7:6] == 2'h2)
        else $error("slot bits wrong");
    a_req_index: assert property (@(posedge aclk) disable iff (!aresetn)
        hdr_valid && !hdr_is_cpl && bar_hit && bar_num != 3'h0 && req_hit
        |=> out_req_id[5:0] == $past(req_idx))
        else $error("index not placed");
    a_bar0_local: assert property (@(posedge aclk) disable iff (!aresetn)
        hdr_valid && !hdr_is_cpl && bar_hit && bar_num == 3'h0 |=> out_kind == 2'h2)
        else $error("bar0 not local");
    a_req_nomatch: assert property (@(posedge aclk) disable iff (!aresetn)
        hdr_valid && !hdr_is_cpl && !req_hit && !(bar_hit && bar_num == 3'h0)
        |=> out_kind == 2'h0)
        else $error("unmatched request forwarded");
    a_bus_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        s_arvalid && s_arready |=> s_rvalid)
        else $error("read not answered");
    c_req_fwd: cover property (@(posedge aclk) out_valid && out_kind == 2'h1 && !$past(hdr_is_cpl));
    c_cpl_fwd: cover property (@(posedge aclk) out_valid && out_kind == 2'h1 && $past(hdr_is_cpl));
    c_local: cover property (@(posedge aclk) out_valid && out_kind == 2'h2);
    c_drop: cover property (@(posedge aclk) out_valid && out_kind == 2'h0);
endmodule // ntbx_translate
`default_nettype wire

// File: inc/ntbx_pkg.sv
`default_nettype none
package ntbx_pkg;
    // Mapping table geometry
    localparam int MAP_ENTRIES = 64;
    localparam int MAP_IDX_W = 6;
    localparam int NUM_PARTS = 8;
    localparam int PART_W = 3;
    localparam int NUM_BARS = 6;
    localparam int LUT_ENTRIES = 12;
    localparam int LUT_IDX_W = 4;
    // Mapping table entry fields
    localparam int F_VALID = 0;
    localparam int F_FN_LO = 1;
    localparam int F_SLOT_LO = 4;
    localparam int F_BUS_LO = 9;
    localparam int F_PART_LO = 17;
    localparam int F_ATH = 29;
    localparam int F_CSH = 30;
    localparam int F_RSH = 31;
    localparam logic [31:0] MAP_RESET = 32'h0000_0000;
    localparam logic [31:0] MAP_WMASK = 32'he00f_ffff;
    // Register map, byte addresses
    localparam logic [11:0] A_MAP_BASE = 12'h000;
    localparam logic [11:0] A_BAR_BASE = 12'h100;
    localparam logic [11:0] A_BAR_MASK = 12'h140;
    localparam logic [11:0] A_BAR_CFG = 12'h180;
    localparam logic [11:0] A_DIR_BASE = 12'h1c0;
    localparam logic [11:0] A_LUT_BASE = 12'h200;
    localparam logic [11:0] A_EP_ID = 12'h280;
    localparam logic [11:0] A_LOC_CFG = 12'h2a0;
    localparam logic [11:0] A_CAPTURE = 12'h2a4;
    localparam logic [11:0] A_STATUS = 12'h2a8;
    // Bar configuration fields
    localparam int BC_EN = 0;
    localparam int BC_LUT = 1;
    localparam int BC_PART_LO = 4;
    localparam int BC_SHIFT_LO = 8;
    // Lut entry fields
    localparam int L_VALID = 0;
    localparam int L_PART_LO = 1;
    // Requester id bits tested on completions
    localparam logic [1:0] CPL_TAG = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Result kind
    localparam logic [1:0] K_DROP = 2'h0;
    localparam logic [1:0] K_FWD = 2'h1;
    localparam logic [1:0] K_LOCAL = 2'h2;
endpackage : ntbx_pkg
`default_nettype wire

// File: dv/ntbx_link_peer.sv
`default_nettype none
module ntbx_link_peer (
    // Clock
    input wire logic aclk,
    // Header toward the bridge
    output logic hdr_valid,
    output logic hdr_is_cpl,
    output logic [2:0] hdr_src_part,
    output logic [15:0] hdr_req_id,
    output logic [15:0] hdr_cpl_id,
    output logic [63:0] hdr_addr
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle link at time zero
    initial
    begin
        hdr_valid = 1'b0;
        hdr_is_cpl = 1'b0;
        hdr_src_part = 3'h0;
        hdr_req_id = 16'h0000;
        hdr_cpl_id = 16'h0000;
        hdr_addr = 64'h0;
    end

    // One header per call; fields inverted afterwards so stale values never match
    task send(input logic c, input logic [2:0] p, input logic [15:0] r,
              input logic [15:0] q, input logic [63:0] a);
        @(posedge aclk);
        hdr_valid <= 1'b1;
        hdr_is_cpl <= c;
        hdr_src_part <= p;
        hdr_req_id <= r;
        hdr_cpl_id <= q;
        hdr_addr <= a;
        @(posedge aclk);
        hdr_valid <= 1'b0;
        hdr_is_cpl <= ~c;
        hdr_src_part <= ~p;
        hdr_req_id <= ~r;
        hdr_cpl_id <= ~q;
        hdr_addr <= ~a;
    endtask
endmodule // ntbx_link_peer
`default_nettype wire

// File: dv/ntb_id_addr_translation_bench.sv
`default_nettype none
module ntb_id_addr_translation_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rd;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, hv, hc, ov, oat, ocs, ors;
    logic [1:0] bresp, rresp, okind, rsp;
    logic [31:0] rdata;
    logic [2:0] hp, opart, obar;
    logic [15:0] hr, hq, orid, ocid;
    logic [63:0] ha, oaddr;
    int bad_count = 0, num_checks = 0;
    // Setup: map entries, endpoint ids, lut bar 2, local bar 0, lut slot 0, direct bar 1
    logic [11:0] sa [22] = '{12'h014, 12'h00c, 12'h280, 12'h284, 12'h110, 12'h114, 12'h150,
        12'h154, 12'h188, 12'h200, 12'h204, 12'h100, 12'h104, 12'h140, 12'h144, 12'h180,
        12'h108, 12'h148, 12'h14c, 12'h184, 12'h1c8, 12'h288};
    logic [31:0] sd [22] = '{32'he000_0011, 32'h0000_0010, 32'h0000_0101, 32'h0000_0100,
        32'he000_0000, 32'h0, 32'hff00_0000, 32'hffff_ffff, 32'h0000_1403, 32'h1100_0003,
        32'h0, 32'h0, 32'h0, 32'hffff_f000, 32'hffff_ffff, 32'h0000_0001,
        32'he100_0000, 32'hfff0_0000, 32'hffff_ffff, 32'h0000_0021, 32'h1850_0000, 32'h0000_0200};

    always #25 aclk = ~aclk;

    ntbx_translate uut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
        .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
        .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
        .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
        .hdr_valid(hv), .hdr_is_cpl(hc), .hdr_src_part(hp), .hdr_req_id(hr),
        .hdr_cpl_id(hq), .hdr_addr(ha), .out_valid(ov), .out_kind(okind), .out_part(opart),
        .out_req_id(orid), .out_cpl_id(ocid), .out_addr(oaddr), .out_bar(obar),
        .out_addr_type(oat), .out_cpl_snoop(ocs), .out_req_snoop(ors));

    ntbx_link_peer peer (.aclk(aclk), .hdr_valid(hv), .hdr_is_cpl(hc), .hdr_src_part(hp),
        .hdr_req_id(hr), .hdr_cpl_id(hq), .hdr_addr(ha));

    task chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Handshakes judged on values that stand before the sampling edge
    task wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, tb;
        n = 0;
        tb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb && n < 100)
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rsp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            n++;
        end
        if (!tb) chk(64'h1, 64'h0);
    endtask

    task rdx(input logic [11:0] a, input logic [31:0] e);
        int n;
        logic ta, tr;
        n = 0;
        tr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr && n < 100)
        begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            rd = rdata;
            rsp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            n++;
        end
        chk({rsp, rd}, {ntbx_pkg::RESP_OKAY, e});
    endtask

    // One header through the bridge; result stands one cycle after it
    task tx(input logic c, input logic [2:0] p, input logic [15:0] r, input logic [63:0] a,
            input logic [1:0] k, input logic [2:0] ep, input logic [15:0] er,
            input logic [63:0] ex);
        peer.send(c, p, r, 16'h0001, a);
        #1;
        chk(ov, 1'b1);
        chk(okind, k);
        if (k === ntbx_pkg::K_FWD)
        begin
            chk({opart, orid, ors, ocs, oat}, {ep, er, ~c, c, ~c});
            chk(c ? ocid : oaddr, ex);
        end
        if (k === ntbx_pkg::K_LOCAL) chk(obar, 3'h0);
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run of under 200 cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        summarize();
    end

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rdx(12'h020, ntbx_pkg::MAP_RESET);
        wr(12'h014, 32'hffff_ffff);
        rdx(12'h014, ntbx_pkg::MAP_WMASK);
        wr(12'h800, 32'h1);
        chk(rsp, ntbx_pkg::RESP_SLVERR);
        rdx(12'h800, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 22; i++) wr(sa[i], sd[i]);
        tx(0, 0, 16'h0008, 64'he000_1234, 1, 1, 16'h0185, 64'h1100_1234);
        tx(0, 0, 16'h0008, 64'he100_0042, 1, 2, 16'h0285, 64'h1850_0042);
        tx(0, 0, 16'h0010, 64'he000_1234, 0, 0, 0, 0);
        tx(0, 2, 16'h0008, 64'he000_1234, 0, 0, 0, 0);
        tx(0, 0, 16'h0008, 64'he010_0000, 0, 0, 0, 0);
        $display("test requests done");
        tx(1, 1, 16'h0185, 64'h0, 1, 0, 16'h0008, 64'h0101);
        tx(1, 1, 16'h0145, 64'h0, 0, 0, 0, 0);
        tx(1, 1, 16'h0183, 64'h0, 0, 0, 0, 0);
        $display("test completions done");
        tx(0, 0, 16'h0008, 64'h2a4, 2, 0, 0, 0);
        rdx(12'h2a4, 32'h0000_0008);
        rdx(12'h2a8, 32'h0000_0005);
        $display("test local done");
        summarize();
    end
endmodule // ntb_id_addr_translation_bench
`default_nettype wire
